// ### hw/aisr_pkg.sv
// constants and types shared by both ends of the internal-clock result port
// assumes a single 250 MHz system clock on each end
package aisr_pkg;
	localparam int          CLK_MHZ          = 250;  // system clock rate
	localparam int          RESULT_BITS      = 32;   // bits per transfer
	localparam int          TEST_DELAY_NS    = 23000; // status test delay
	localparam int          TEST_DELAY_ALT_NS = 26000; // notch variant
	localparam int          EXT_OSC_X10      = 36;   // 3.6 osc periods
	localparam int          TEST_CYC         = (TEST_DELAY_NS * CLK_MHZ) / 1000;
	localparam int          TEST_ALT_CYC     = (TEST_DELAY_ALT_NS * CLK_MHZ) / 1000;
	localparam int          SCK_HALF_CYC     = 10;   // half internal SCK
	localparam int          CONV_CYC         = 2000; // model conversion
	localparam int          POR_NS           = 500000; // 0.5 ms
	localparam int          POR_CYC          = (POR_NS / 1000) * CLK_MHZ;
	localparam int          CNT_W            = 20;   // counter width
	localparam logic [31:0] RESULT_RESET     = 32'h0000_0000;
	localparam logic [5:0]  BIT_RESET        = 6'h00;

	// operating mode
	typedef enum logic [1:0] {
		AISR_SINGLE,     // cs controlled single cycle
		AISR_CONTINUOUS, // cs tied low
		AISR_AUTOSTART   // capacitor on cs
	} aisr_mode_e;
endpackage

// ### hw/aisr_if.sv
// pin-level link between the converter end and the host end
// the bench resolves open-drain/weak levels from the enables
`timescale 1ns/1ps
interface aisr_if;
	logic sck_dev_o;   // device SCK value
	logic sck_dev_oe;  // device drives SCK
	logic sck_pu;      // device weak pull-up on SCK
	logic sck_host_o;  // host SCK value
	logic sck_host_oe; // host drives SCK
	logic sck;         // resolved SCK level
	logic sdo_o;       // device data value
	logic sdo_oe;      // device drives data
	logic sdo;         // resolved data level
	logic cs_host_o;   // host chip select value
	logic cs_host_oe;  // host drives chip select
	logic cs_pu;       // device weak pull-up on cs
	logic cs_sink;     // device discharge sink on cs
	logic cs;          // resolved cs level (below threshold = 0)

	modport dev (output sck_dev_o, sck_dev_oe, sck_pu, sdo_o, sdo_oe,
		cs_pu, cs_sink, input sck, cs);
	modport host (output sck_host_o, sck_host_oe, cs_host_o, cs_host_oe,
		input sck, sdo);
endinterface

// ### hw/aisr_sync.sv
// two flip-flop synchroniser with a registered edge history
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/1ps
module aisr_sync (
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      level_o,
	output logic      prev_o
);
	logic [2:0] stage_reg; // stage 0 only feeds stage 1

	// shift in; set value is high as cs and sck idle high
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			stage_reg <= 3'h7;
		end else begin
			stage_reg <= {stage_reg[1:0], async_i};
		end
	end

	assign level_o = stage_reg[1];
	assign prev_o  = stage_reg[2];
endmodule

// ### hw/aisr_device.sv
// converter end: internal-clock serial result output
// assumes mode straps are static and the link is resolved by the bench
`timescale 1ns/1ps
module aisr_device (
	input  wire logic                 sys_clk_i,
	input  wire logic                 reset_i,
	aisr_if.dev                       link,
	input  wire aisr_pkg::aisr_mode_e mode_i,      // wiring of cs pin
	input  wire logic                 ext_osc_i,   // external oscillator in use
	input  wire logic                 notch_alt_i, // simultaneous-notch variant
	input  wire logic [31:0]          result_i,    // next conversion result
	input  wire logic [15:0]          ext_osc_cyc_i, // osc period in cycles
	output logic                      conv_busy_o, // conversion running
	output logic                      int_mode_o   // internal clock selected
);
	typedef enum logic [2:0] {
		ST_POR, ST_CONV, ST_SLEEP, ST_TEST, ST_SHIFT, ST_EXT
	} aisr_dstate_e;

	typedef struct packed {
		aisr_dstate_e   st;
		logic [19:0]    cnt;     // delay counter
		logic [5:0]     bitn;    // rising edges so far
		logic [31:0]    shreg;   // result shift register
		logic           sck;     // driven SCK level
		logic           sck_oe;
		logic           sck_pu;
		logic           sdo;
		logic           sdo_oe;
		logic           cs_pu;
		logic           cs_sink;
		logic           intm;    // internal clock mode latched
		logic           lost;    // SCK left low by cs rise
		logic           busy;    // converting, registered for the output
	} aisr_dev_s;

	aisr_dev_s s_reg;
	aisr_dev_s s_next;
	logic      cs_lv;
	logic      cs_pv;
	logic      sck_lv;
	logic      sck_pv;
	logic      cs_fall;
	logic      cs_rise;
	logic [19:0] test_cyc; // chosen status test delay

	aisr_sync u_cs (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.async_i(link.cs), .level_o(cs_lv), .prev_o(cs_pv));
	aisr_sync u_sck (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.async_i(link.sck), .level_o(sck_lv), .prev_o(sck_pv));

	assign cs_fall = cs_pv & ~cs_lv;
	assign cs_rise = ~cs_pv & cs_lv;

	// status test delay by oscillator choice
	always_comb begin
		if (ext_osc_i) begin
			test_cyc = 20'((32'(ext_osc_cyc_i) * aisr_pkg::EXT_OSC_X10
				+ 9) / 10);
		end else if (notch_alt_i) begin
			test_cyc = 20'(aisr_pkg::TEST_ALT_CYC);
		end else begin
			test_cyc = 20'(aisr_pkg::TEST_CYC);
		end
	end

	// whole device sequence
	always_comb begin
		s_next = s_reg;
		s_next.cnt = s_reg.cnt + 20'h00001;
		// pull-up follows the pin: off once low, back on once high
		// a pin left low by an outside driver thus stays low
		s_next.sck_pu = sck_lv;
		// data released while cs high in single mode
		if (mode_i == aisr_pkg::AISR_SINGLE && cs_lv) begin
			s_next.sdo_oe = 1'b0;
		end
		case (s_reg.st)
			ST_POR: begin
				s_next.sck_pu = 1'b1;
				// single mode picks its clock at every cs fall, so it
				// need not sit out the strap wait
				if (mode_i == aisr_pkg::AISR_SINGLE ||
					s_reg.cnt >= 20'(aisr_pkg::POR_CYC - 1)) begin
					s_next.intm = sck_lv;
					s_next.st   = sck_lv ? ST_CONV : ST_EXT;
					s_next.cnt  = '0;
					s_next.cs_pu = (mode_i == aisr_pkg::AISR_AUTOSTART);
				end
			end
			ST_CONV, ST_SLEEP: begin
				if (s_reg.st == ST_CONV &&
					s_reg.cnt >= 20'(aisr_pkg::CONV_CYC - 1)) begin
					s_next.st    = ST_SLEEP;
					s_next.cnt   = '0;
					s_next.shreg = result_i;
					if (mode_i == aisr_pkg::AISR_CONTINUOUS) begin
						s_next.sck = 1'b0;
						s_next.sdo = 1'b0;
					end else if (mode_i == aisr_pkg::AISR_AUTOSTART) begin
						s_next.sck = 1'b0;
						s_next.sdo = 1'b0;
						s_next.cs_pu   = 1'b0;
						s_next.cs_sink = 1'b1;
						s_next.sck_pu  = 1'b1;
					end else if (!cs_lv && s_reg.intm) begin
						s_next.sdo = 1'b0;
						s_next.st  = ST_TEST;
					end
				end else if (s_reg.st == ST_SLEEP &&
					mode_i == aisr_pkg::AISR_CONTINUOUS) begin
					if (s_reg.cnt >= 20'(aisr_pkg::SCK_HALF_CYC - 1)) begin
						s_next.st   = ST_SHIFT;
						s_next.cnt  = '0;
						s_next.sck  = 1'b1; // first rise ends the sleep
						s_next.bitn = 6'h01;
					end
				end else if (s_reg.st == ST_SLEEP &&
					mode_i == aisr_pkg::AISR_AUTOSTART) begin
					if (!cs_lv) begin
						s_next.intm    = sck_lv;
						s_next.cs_sink = 1'b0;
						s_next.st      = ST_SHIFT;
						s_next.cnt     = '0;
					end
				end else if (cs_fall && mode_i == aisr_pkg::AISR_SINGLE) begin
					// mode picked by SCK level at cs fall
					s_next.intm = sck_lv & ~s_reg.lost;
					s_next.lost = 1'b0;
					if (sck_lv && !s_reg.lost) begin
						s_next.sck    = 1'b0;
						s_next.sck_oe = 1'b1;
						s_next.sdo_oe = 1'b1;
						s_next.sdo    = (s_reg.st == ST_CONV);
						if (s_reg.st == ST_SLEEP) begin
							s_next.st  = ST_TEST;
							s_next.cnt = '0;
						end
					end else begin
						s_next.st = (s_reg.st == ST_SLEEP) ? ST_EXT : s_reg.st;
					end
				end else if (cs_rise && mode_i == aisr_pkg::AISR_SINGLE) begin
					s_next.sck_oe = 1'b0;
					s_next.sck_pu = 1'b1;
				end
			end
			ST_TEST: begin
				if (cs_lv && mode_i == aisr_pkg::AISR_SINGLE) begin
					s_next.st     = ST_SLEEP;
					s_next.sck_oe = 1'b0;
					s_next.sck_pu = 1'b1;
				end else if (s_reg.cnt >= test_cyc - 20'h00001) begin
					// first rise lands exactly one test delay on
					s_next.st   = ST_SHIFT;
					s_next.cnt  = '0;
					s_next.sck  = 1'b1;
					s_next.bitn = 6'h01;
				end
			end
			ST_SHIFT: begin
				if (cs_lv && mode_i == aisr_pkg::AISR_SINGLE) begin
					s_next.lost   = ~s_reg.sck;
					s_next.sck_oe = 1'b0;
					s_next.st     = ST_CONV;
					s_next.cnt    = '0;
					s_next.bitn   = aisr_pkg::BIT_RESET;
				end else if (s_reg.cnt >= 20'(aisr_pkg::SCK_HALF_CYC - 1)) begin
					s_next.cnt = '0;
					if (s_reg.bitn == 6'(aisr_pkg::RESULT_BITS)) begin
						// last bit stands a full half period past the
						// 32nd rise, so no receiver races the data high
						s_next.sdo   = 1'b1;
						s_next.st    = ST_CONV;
						s_next.bitn  = aisr_pkg::BIT_RESET;
						s_next.cs_pu = (mode_i ==
							aisr_pkg::AISR_AUTOSTART);
					end else if (!s_reg.sck) begin
						s_next.sck  = 1'b1;
						s_next.bitn = s_reg.bitn + 6'h01;
					end else begin
						s_next.sck   = 1'b0;
						s_next.sdo   = s_reg.shreg[31];
						s_next.shreg = {s_reg.shreg[30:0], 1'b0};
					end
				end
			end
			ST_EXT: begin
				// external clock mode is outside this port
				s_next.sck_oe = 1'b0;
				if (cs_fall && sck_lv) begin
					s_next.intm = 1'b1;
					s_next.st   = ST_CONV;
				end
			end
			default: begin
				s_next.st = ST_POR;
			end
		endcase
		// never pull up against our own sck_oe low drive; the continuous and autostart drive is not covered
		if (s_next.sck_oe && !s_next.sck) begin
			s_next.sck_pu = 1'b0;
		end
		s_next.busy = (s_next.st == ST_CONV);
	end

	// single state register
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			s_reg <= '{st: ST_POR, cnt: '0, bitn: aisr_pkg::BIT_RESET,
				shreg: aisr_pkg::RESULT_RESET, sck: 1'b1, sck_oe: 1'b0,
				sck_pu: 1'b1, sdo: 1'b1, sdo_oe: 1'b0, cs_pu: 1'b0,
				cs_sink: 1'b0, intm: 1'b0, lost: 1'b0, busy: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	// continuous and autostart drive pins whenever internal
	assign link.sck_dev_o  = s_reg.sck;
	assign link.sck_dev_oe = s_reg.sck_oe |
		(s_reg.intm && mode_i != aisr_pkg::AISR_SINGLE);
	assign link.sck_pu     = s_reg.sck_pu;
	assign link.sdo_o      = s_reg.sdo;
	assign link.sdo_oe     = s_reg.sdo_oe |
		(s_reg.intm && mode_i != aisr_pkg::AISR_SINGLE);
	assign link.cs_pu      = s_reg.cs_pu;
	assign link.cs_sink    = s_reg.cs_sink;
	assign conv_busy_o     = s_reg.busy;
	assign int_mode_o      = s_reg.intm;
endmodule

// ### hw/aisr_host.sv
// host end: drives chip select, captures 32 bits on SCK rise
// assumes the device supplies SCK; host never drives SCK low
`timescale 1ns/1ps
module aisr_host (
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	aisr_if.host             link,
	input  wire logic        start_i,   // pulse: lower cs to read
	input  wire logic        abort_i,   // pulse: raise cs early; ignored while SCK is low
	output logic [31:0]      word_o,    // received word
	output logic             word_vld_o, // one-cycle pulse
	output logic             cs_low_o   // cs currently driven low
);
	typedef struct packed {
		logic        cs;
		logic [31:0] sh;
		logic [5:0]  n;
		logic [31:0] word;
		logic        vld;
	} aisr_host_s;

	aisr_host_s h_reg;
	aisr_host_s h_next;
	logic       sck_lv;
	logic       sck_pv;
	logic       sdo_lv;
	logic       sdo_pv;

	aisr_sync u_sck (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.async_i(link.sck), .level_o(sck_lv), .prev_o(sck_pv));
	aisr_sync u_sdo (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.async_i(link.sdo), .level_o(sdo_lv), .prev_o(sdo_pv));

	// capture on rising SCK while cs low
	always_comb begin
		h_next = h_reg;
		h_next.vld = 1'b0;
		if (start_i) begin
			h_next.cs = 1'b0;
			h_next.n  = 6'h00;
		end
		// raise cs only while SCK is high
		if (abort_i && sck_lv) begin
			h_next.cs = 1'b1;
		end
		if (!h_reg.cs && sck_lv && !sck_pv) begin
			h_next.sh = {h_reg.sh[30:0], sdo_lv};
			h_next.n  = h_reg.n + 6'h01;
			if (h_reg.n == 6'(aisr_pkg::RESULT_BITS - 1)) begin
				h_next.word = {h_reg.sh[30:0], sdo_lv};
				h_next.vld  = 1'b1;
				h_next.n    = 6'h00;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			h_reg <= '{cs: 1'b1, sh: '0, n: 6'h00, word: '0, vld: 1'b0};
		end else begin
			h_reg <= h_next;
		end
	end

	// host never drives SCK, keeping internal mode selectable
	assign link.sck_host_o  = 1'b1;
	assign link.sck_host_oe = 1'b0;
	assign link.cs_host_o   = h_reg.cs;
	assign link.cs_host_oe  = 1'b1;
	assign word_o           = h_reg.word;
	assign word_vld_o       = h_reg.vld;
	assign cs_low_o         = ~h_reg.cs;
endmodule

// ### verification/aisr_props.sv
// checker for the result port link, sees only the interface's signals
// assumes the testbench instantiates it beside the link, no bind
`timescale 1ns/1ps
module aisr_props (
	input wire logic sys_clk_i,
	input wire logic reset_i,
	input wire logic sck_dev_o,
	input wire logic sck_dev_oe,
	input wire logic sck_pu,
	input wire logic sck_host_oe,
	input wire logic sck,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic cs
);
	localparam int HALF = aisr_pkg::SCK_HALF_CYC; // half sck period
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	logic [19:0] hi_cnt; // length of current high run
	logic [19:0] lo_cnt; // length of current low run
	logic [5:0]  nrise;  // rises since the last long low
	// run lengths; wide enough never to wrap within a run
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			hi_cnt <= 20'h00000;
			lo_cnt <= 20'h00000;
			nrise  <= 6'h00;
		end else begin
			hi_cnt <= sck ? hi_cnt + 20'h00001 : 20'h00000;
			lo_cnt <= sck ? 20'h00000 : lo_cnt + 20'h00001;
			// cs high ends any frame; a long low opens a new one
			if (cs) begin
				nrise <= 6'h00;
			end else if (sck && lo_cnt > HALF) begin
				nrise <= 6'h01;
			end else if (sck && lo_cnt != 20'h00000) begin
				nrise <= nrise + 6'h01;
			end
		end
	end
	data_release_a: assert property (cs [*5] |-> !sdo_oe)
		else $error("data driven while cs high");
	pu_off_low_a: assert property (sck_dev_oe && !sck_dev_o |-> !sck_pu)
		else $error("pull-up on while sck driven low");
	sck_drop_a: assert property ($fell(cs) && sck |->
		##[2:6] (sck_dev_oe && !sck_dev_o))
		else $error("sck not lowered after cs fall");
	pu_at_fall_a: assert property ($fell(cs) |->
		(sck_pu || sck_dev_oe || sck_host_oe))
		else $error("sck left floating at cs fall");
	high_half_a: assert property ($fell(sck) && nrise != 0 &&
		nrise < 6'h20 && hi_cnt < 100 |-> hi_cnt == HALF)
		else $error("sck high phase wrong length");
	low_half_a: assert property (sck && lo_cnt != 0 && lo_cnt < 100 |->
		lo_cnt == HALF)
		else $error("sck low phase wrong length");
	frame_len_a: assert property (nrise <= 6'h20)
		else $error("more than 32 rises in a frame");
	end_hold_a: assert property (sck && lo_cnt != 0 && nrise == 6'h1F && !cs
		|-> ##12 (sck && (cs || sdo)))
		else $error("sck or data not high after last rise");
	abort_hold_a: assert property ($rose(cs) && sck && nrise != 0 &&
		nrise != 6'h20 |-> ##1 sck [*8])
		else $error("sck still toggling after abort");
	cover property (sck && lo_cnt != 0 && nrise == 6'h1F);
	cover property ($rose(cs) && nrise != 0 && nrise != 6'h20);
	cover property ($fell(cs) ##6 sdo);
endmodule

// ### verification/testbench.sv
// self-checking bench: device and host ends joined over the link
// assumes single-cycle mode only, as each mode change costs a power-on wait
`timescale 1ns/1ps
module testbench;
	logic                 sys_clk_i, reset_i, start_i, abort_i;
	logic                 ext_osc_i, notch_alt_i, tgl, sck_last;
	logic                 word_vld_o, cs_low_o, conv_busy_o, int_mode_o;
	logic [15:0]          ext_osc_cyc_i;
	logic [31:0]          result_i, word_o;
	aisr_pkg::aisr_mode_e mode_i;
	int                   err_count, comparisons;
	logic                 q[$];     // data seen at each sck rise
	int unsigned          res_q[$]; // results of pending conversions
	aisr_if lnk ();
	// a driver wins, then a pull-up; released sck holds, data wanders
	assign lnk.sck = lnk.sck_dev_oe ? lnk.sck_dev_o :
		lnk.sck_host_oe ? lnk.sck_host_o : (lnk.sck_pu | sck_last);
	assign lnk.sdo = lnk.sdo_oe ? lnk.sdo_o : tgl;
	assign lnk.cs  = lnk.cs_host_oe ? lnk.cs_host_o : !lnk.cs_sink;
	aisr_device aisr_device_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.link(lnk), .mode_i(mode_i), .ext_osc_i(ext_osc_i),
		.notch_alt_i(notch_alt_i), .result_i(result_i),
		.ext_osc_cyc_i(ext_osc_cyc_i), .conv_busy_o(conv_busy_o),
		.int_mode_o(int_mode_o));
	aisr_host aisr_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.link(lnk), .start_i(start_i), .abort_i(abort_i), .word_o(word_o),
		.word_vld_o(word_vld_o), .cs_low_o(cs_low_o));
	aisr_props aisr_props_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.sck_dev_o(lnk.sck_dev_o), .sck_dev_oe(lnk.sck_dev_oe),
		.sck_pu(lnk.sck_pu), .sck_host_oe(lnk.sck_host_oe), .sck(lnk.sck),
		.sdo(lnk.sdo), .sdo_oe(lnk.sdo_oe), .cs(lnk.cs));
	// 250 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	// last sck level and a wandering level for released data
	always @(posedge sys_clk_i) begin
		sck_last <= lnk.sck;
		tgl      <= !tgl;
	end
	// bits as a receiver latches them, on each sck rise
	always @(posedge lnk.sck)
		if (lnk.cs === 1'b0) q.push_back(lnk.sdo);
	task automatic check(input logic [31:0] got, exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// delays are measured by the bench, so a few cycles of slack
	task automatic check_near(input int got, exp);
		comparisons++;
		if (got < exp - 8 || got > exp + 8) begin
			err_count++;
			$display("BAD %0t delay %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// one-cycle pulse on start or abort, entered at a falling edge
	task automatic kick(input bit ab);
		if (ab) abort_i = 1'b1;
		else start_i = 1'b1;
		@(negedge sys_clk_i);
		start_i = 1'b0;
		abort_i = 1'b0;
	endtask
	// new conversion running: queue the result it will take
	task automatic next_result();
		result_i = $urandom;
		res_q.push_back(result_i);
	endtask
	// host lets go of cs with sck high; data must go quiet
	task automatic release_cs();
		int n;
		kick(1'b1);
		for (n = 0; n < 20 && cs_low_o !== 1'b0; n++) @(negedge sys_clk_i);
		repeat (6) @(negedge sys_clk_i);
		check(lnk.sdo_oe, 1'b0, "data released");
	endtask
	// full read; busy means cs falls while converting
	task automatic do_read(input int dly, input bit busy);
		int n;
		logic [31:0] exp, bits;
		exp = res_q.pop_front() >> 1;
		q.delete();
		kick(1'b0);
		for (n = 0; n < 20 && lnk.sck !== 1'b0; n++) @(negedge sys_clk_i);
		check(lnk.sdo, busy, "status flag");
		for (n = 0; n < 3000 && conv_busy_o !== 1'b0; n++) @(negedge sys_clk_i);
		check(conv_busy_o, 1'b0, "conversion end");
		for (n = 0; n < 20000 && lnk.sck !== 1'b1; n++) @(negedge sys_clk_i);
		check_near(n, dly);
		for (n = 0; n < 1000 && word_vld_o !== 1'b1; n++) @(negedge sys_clk_i);
		check(word_o, exp, "word");
		check(q.size(), 32, "rise count");
		for (n = 0; n < 32; n++) bits[31 - n] = q[n];
		check(bits, exp, "wire bits");
		// data goes high one half period after the last rise
		repeat (aisr_pkg::SCK_HALF_CYC) @(negedge sys_clk_i);
		check({lnk.sck, lnk.sdo, conv_busy_o}, 3'h7, "after frame");
		check(int_mode_o, 1'b1, "internal mode");
		next_result();
		release_cs();
	endtask
	// abort after five rises; conversion must restart at once
	task automatic do_abort();
		int n;
		q.delete();
		kick(1'b0);
		for (n = 0; n < 30000 && q.size() < 5; n++) @(negedge sys_clk_i);
		// host only lets go once its synchroniser shows SCK high
		repeat (3) @(negedge sys_clk_i);
		kick(1'b1);
		for (n = 0; n < 10 && conv_busy_o !== 1'b1; n++) @(negedge sys_clk_i);
		check(conv_busy_o, 1'b1, "abort restart");
		check(q[0], 1'b0, "first flag");
		res_q.delete();
		next_result();
		for (n = 0; n < 20 && cs_low_o !== 1'b0; n++) @(negedge sys_clk_i);
	endtask
	// watchdog, well past the expected run length
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		err_count++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end
	// main sequence
	initial begin
		int i, dly, seed;
		seed = $urandom(45);
		{reset_i, start_i, abort_i, tgl, ext_osc_i, notch_alt_i} = 6'h20;
		mode_i = aisr_pkg::AISR_SINGLE;
		ext_osc_cyc_i = 16'h0064;
		result_i = $urandom;
		err_count = 0;
		comparisons = 0;
		repeat (4) @(negedge sys_clk_i);
		reset_i = 1'b0;
		// single mode has no strap wait; a short settle is enough
		repeat (10) @(negedge sys_clk_i);
		do_abort();
		// alternating busy and idle reads: default delay both ways, notch variant idle, external oscillator busy
		for (i = 0; i < 4; i++) begin
			ext_osc_i = (i == 2);
			notch_alt_i = (i == 1);
			ext_osc_cyc_i = 16'(100 + $urandom_range(0, 50));
			dly = ext_osc_i ? (36 * ext_osc_cyc_i + 9) / 10 :
				notch_alt_i ? aisr_pkg::TEST_ALT_CYC : aisr_pkg::TEST_CYC;
			if (i % 2 == 1)
				for (int n = 0; n < 3000 && conv_busy_o !== 1'b0; n++)
					@(negedge sys_clk_i);
			do_read(dly, i % 2 == 0);
		end
		print_verdict();
	end
endmodule
